// file: hw/phylt_consts.svh
// Purpose: Offsets, masks, resets and field positions of the PHY test regs
// Assumes: Byte addresses in the switch configuration space
// Notes: Definitions only
`ifndef PHYLT_CONSTS_SVH
`define PHYLT_CONSTS_SVH

`define PHYLT_ADDR_W 12
`define PHYLT_OFF_LANE_STAT 12'h1f4
`define PHYLT_OFF_SPEED 12'h208
`define PHYLT_OFF_COMPL 12'h20c
`define PHYLT_OFF_EVEN_CMD 12'h220
`define PHYLT_OFF_ODD_CMD 12'h224
`define PHYLT_OFF_EVEN_HOLD 12'h230

`define PHYLT_RST_ZERO 32'h0000_0000
`define PHYLT_MASK_SPEED 32'hffff_ffff
`define PHYLT_MASK_COMPL 32'h0000_ffff
`define PHYLT_MASK_EVEN_CMD 32'h7770_0077
`define PHYLT_MASK_ODD_CMD 32'h7770_0070
`define PHYLT_MASK_EVEN_HOLD 32'h00ff_e3e3

`define PHYLT_FIELD_ONE 16'h0001
`define PHYLT_RATE_LSB 0
`define PHYLT_EMPH_LSB 16
`define PHYLT_COMPL_LSB 0

// Lane status packing
`define PHYLT_LANE_LO_LSB 0
`define PHYLT_LANE_HI_LSB 12
`define PHYLT_LANE_MID_LSB 16

// Base bit of each port's three test bits, and each bit's offset from it
`define PHYLT_CMD_P0 0
`define PHYLT_CMD_P2 4
`define PHYLT_CMD_P10 20
`define PHYLT_CMD_P12 24
`define PHYLT_CMD_P14 28
`define PHYLT_CMD_P3 4
`define PHYLT_CMD_P11 20
`define PHYLT_CMD_P13 24
`define PHYLT_CMD_P15 28
`define PHYLT_CMD_LB 0
`define PHYLT_CMD_SCR 1
`define PHYLT_CMD_CRX 2

// Even-port disable, quiet and test-rate bit positions
`define PHYLT_DIS_LSB 0
`define PHYLT_QUIET_LSB 8
`define PHYLT_TPR_LSB 16
`define PHYLT_HOLD_P0 0
`define PHYLT_HOLD_P2 1
`define PHYLT_HOLD_P10 5
`define PHYLT_HOLD_P12 6
`define PHYLT_HOLD_P14 7

`endif

// file: hw/phylt_field_reg.sv
// Purpose: One 32-bit read-write register with byte enables and a bit mask
// Assumes: Synchronous active-high reset
// Notes: Bits outside WR_MASK are never stored and read as zero
`timescale 1ns/1ps
`default_nettype none
module phylt_field_reg #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] WR_MASK = 32'hffff_ffff
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic [3:0] be_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] q_out
);
  logic [31:0] q_q;
  logic [31:0] q_d;
  logic [31:0] lane_mask;

  always_comb begin
    lane_mask = {{8{be_in[3]}}, {8{be_in[2]}}, {8{be_in[1]}}, {8{be_in[0]}}};
    q_d = q_q;
    if (wr_en_in) begin
      // Reserved bits stay zero: disabled lanes keep old value, bits outside WR_MASK are cleared
      q_d = ((wdata_in & lane_mask) | (q_q & ~lane_mask)) & WR_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q_q <= RESET_VAL & WR_MASK;
    end else begin
      q_q <= q_d;
    end
  end

  assign q_out = q_q;
endmodule
`default_nettype wire

// file: hw/phylt_pkg.sv
// Purpose: Types of the PHY link test register set
// Assumes: Constants live in phylt_consts.svh
// Notes: Structs carry grouped signals
package phylt_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic upstream;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } phylt_cfg_req_t;

  typedef struct packed {
    logic [15:0] loopback;
    logic [15:0] scrambler_bypass;
    logic [15:0] compliance_rx;
    logic [15:0] force_quiet;
    logic [15:0] hold_quiet;
  } phylt_port_ctl_t;

  typedef struct packed {
    logic rate_gen2;
    logic emphasis_3p5db;
    logic compliance_enter;
  } phylt_link_ctl_t;

endpackage

// file: hw/phylt_regs.sv
// Purpose: PHY link test control and lane status registers of the switch
// Assumes: Config accesses arrive on the core clock, one word per request
// Notes: Read data answers one cycle after the read strobe
`include "phylt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module phylt_regs (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire phylt_pkg::phylt_cfg_req_t cfg_req_in,
  input wire logic [11:0] lane_link_up_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rd_valid_out,
  output phylt_pkg::phylt_link_ctl_t link_ctl_out,
  output phylt_pkg::phylt_port_ctl_t port_ctl_out,
  output logic [7:0] even_test_rate_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic hit_lane;
  logic hit_speed;
  logic hit_compl;
  logic hit_even_cmd;
  logic hit_odd_cmd;
  logic hit_even_hold;
  logic [11:0] word_addr;
  logic [31:0] speed_q;
  logic [31:0] compl_q;
  logic [31:0] even_cmd_q;
  logic [31:0] odd_cmd_q;
  logic [31:0] even_hold_q;

  always_comb begin
    hit_lane = 1'b0;
    hit_speed = 1'b0;
    hit_compl = 1'b0;
    hit_even_cmd = 1'b0;
    hit_odd_cmd = 1'b0;
    hit_even_hold = 1'b0;
    // Byte lanes within a word share one decode
    word_addr = {cfg_req_in.addr[11:2], 2'b00};
    if (word_addr == `PHYLT_OFF_LANE_STAT) begin
      hit_lane = 1'b1;
    end else if (word_addr == `PHYLT_OFF_SPEED) begin
      // Downstream port spaces have no such register
      hit_speed = cfg_req_in.upstream;
    end else if (word_addr == `PHYLT_OFF_COMPL) begin
      hit_compl = 1'b1;
    end else if (word_addr == `PHYLT_OFF_EVEN_CMD) begin
      hit_even_cmd = 1'b1;
    end else if (word_addr == `PHYLT_OFF_ODD_CMD) begin
      hit_odd_cmd = 1'b1;
    end else if (word_addr == `PHYLT_OFF_EVEN_HOLD) begin
      hit_even_hold = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers

  phylt_field_reg #(
    .RESET_VAL(`PHYLT_RST_ZERO),
    .WR_MASK(`PHYLT_MASK_SPEED)
  ) u_speed (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(cfg_req_in.wr && hit_speed),
    .be_in(cfg_req_in.be),
    .wdata_in(cfg_req_in.wdata),
    .q_out(speed_q)
  );

  phylt_field_reg #(
    .RESET_VAL(`PHYLT_RST_ZERO),
    .WR_MASK(`PHYLT_MASK_COMPL)
  ) u_compl (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(cfg_req_in.wr && hit_compl),
    .be_in(cfg_req_in.be),
    .wdata_in(cfg_req_in.wdata),
    .q_out(compl_q)
  );

  phylt_field_reg #(
    .RESET_VAL(`PHYLT_RST_ZERO),
    .WR_MASK(`PHYLT_MASK_EVEN_CMD)
  ) u_even_cmd (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(cfg_req_in.wr && hit_even_cmd),
    .be_in(cfg_req_in.be),
    .wdata_in(cfg_req_in.wdata),
    .q_out(even_cmd_q)
  );

  phylt_field_reg #(
    .RESET_VAL(`PHYLT_RST_ZERO),
    .WR_MASK(`PHYLT_MASK_ODD_CMD)
  ) u_odd_cmd (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(cfg_req_in.wr && hit_odd_cmd),
    .be_in(cfg_req_in.be),
    .wdata_in(cfg_req_in.wdata),
    .q_out(odd_cmd_q)
  );

  phylt_field_reg #(
    .RESET_VAL(`PHYLT_RST_ZERO),
    .WR_MASK(`PHYLT_MASK_EVEN_HOLD)
  ) u_even_hold (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(cfg_req_in.wr && hit_even_hold),
    .be_in(cfg_req_in.be),
    .wdata_in(cfg_req_in.wdata),
    .q_out(even_hold_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lane status, control decode and read data

  logic [31:0] lane_q;
  logic [31:0] lane_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rd_valid_q;
  logic rd_valid_d;
  phylt_pkg::phylt_link_ctl_t link_q;
  phylt_pkg::phylt_link_ctl_t link_d;
  phylt_pkg::phylt_port_ctl_t port_q;
  phylt_pkg::phylt_port_ctl_t port_d;
  logic [2:0] tst [16];
  logic [7:0] dis_bits;
  logic [7:0] quiet_bits;

  always_comb begin
    // Hardware-owned only; no write path reaches it
    lane_d = `PHYLT_RST_ZERO;
    lane_d[`PHYLT_LANE_LO_LSB +: 4] = lane_link_up_in[3:0];
    lane_d[`PHYLT_LANE_MID_LSB +: 4] = lane_link_up_in[7:4];
    lane_d[`PHYLT_LANE_HI_LSB +: 4] = lane_link_up_in[11:8];

    link_d.rate_gen2 =
      speed_q[`PHYLT_RATE_LSB +: 16] == `PHYLT_FIELD_ONE;
    link_d.emphasis_3p5db =
      speed_q[`PHYLT_EMPH_LSB +: 16] == `PHYLT_FIELD_ONE;
    // Only the exact value 1h acts; all else is ignored by training
    link_d.compliance_enter =
      compl_q[`PHYLT_COMPL_LSB +: 16] == `PHYLT_FIELD_ONE;

    for (int i = 0; i < 16; i++) begin
      tst[i] = 3'b000;
    end
    tst[0] = even_cmd_q[`PHYLT_CMD_P0 +: 3];
    tst[2] = even_cmd_q[`PHYLT_CMD_P2 +: 3];
    tst[10] = even_cmd_q[`PHYLT_CMD_P10 +: 3];
    tst[12] = even_cmd_q[`PHYLT_CMD_P12 +: 3];
    tst[14] = even_cmd_q[`PHYLT_CMD_P14 +: 3];
    tst[3] = odd_cmd_q[`PHYLT_CMD_P3 +: 3];
    tst[11] = odd_cmd_q[`PHYLT_CMD_P11 +: 3];
    tst[13] = odd_cmd_q[`PHYLT_CMD_P13 +: 3];
    tst[15] = odd_cmd_q[`PHYLT_CMD_P15 +: 3];
    for (int i = 0; i < 16; i++) begin
      port_d.loopback[i] = tst[i][`PHYLT_CMD_LB];
      port_d.scrambler_bypass[i] = tst[i][`PHYLT_CMD_SCR];
      port_d.compliance_rx[i] = tst[i][`PHYLT_CMD_CRX];
    end

    port_d.force_quiet = 16'h0000;
    port_d.hold_quiet = 16'h0000;
    dis_bits = even_hold_q[`PHYLT_DIS_LSB +: 8];
    quiet_bits = even_hold_q[`PHYLT_QUIET_LSB +: 8];
    port_d.force_quiet[0] = dis_bits[`PHYLT_HOLD_P0];
    port_d.force_quiet[2] = dis_bits[`PHYLT_HOLD_P2];
    port_d.force_quiet[10] = dis_bits[`PHYLT_HOLD_P10];
    port_d.force_quiet[12] = dis_bits[`PHYLT_HOLD_P12];
    port_d.force_quiet[14] = dis_bits[`PHYLT_HOLD_P14];
    port_d.hold_quiet[0] = quiet_bits[`PHYLT_HOLD_P0];
    port_d.hold_quiet[2] = quiet_bits[`PHYLT_HOLD_P2];
    port_d.hold_quiet[10] = quiet_bits[`PHYLT_HOLD_P10];
    port_d.hold_quiet[12] = quiet_bits[`PHYLT_HOLD_P12];
    port_d.hold_quiet[14] = quiet_bits[`PHYLT_HOLD_P14];

    // Unmapped and downstream-speed reads answer zero
    rd_valid_d = cfg_req_in.rd;
    rdata_d = `PHYLT_RST_ZERO;
    if (cfg_req_in.rd) begin
      if (hit_lane) begin
        rdata_d = lane_q;
      end else if (hit_speed) begin
        rdata_d = speed_q;
      end else if (hit_compl) begin
        rdata_d = compl_q;
      end else if (hit_even_cmd) begin
        rdata_d = even_cmd_q;
      end else if (hit_odd_cmd) begin
        rdata_d = odd_cmd_q;
      end else if (hit_even_hold) begin
        rdata_d = even_hold_q;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lane_q <= `PHYLT_RST_ZERO;
      rdata_q <= `PHYLT_RST_ZERO;
      rd_valid_q <= 1'b0;
      link_q <= '0;
      port_q <= '0;
    end else begin
      lane_q <= lane_d;
      rdata_q <= rdata_d;
      rd_valid_q <= rd_valid_d;
      link_q <= link_d;
      port_q <= port_d;
    end
  end

  // Decoded controls lag the register by one cycle to keep outputs flopped
  assign cfg_rdata_out = rdata_q;
  assign cfg_rd_valid_out = rd_valid_q;
  assign link_ctl_out = link_q;
  assign port_ctl_out = port_q;
  assign even_test_rate_out = even_hold_q[`PHYLT_TPR_LSB +: 8];

endmodule
`default_nettype wire

// file: test/phylt_regs_properties.sv
// Purpose: Concurrent checks on the PHY link test register ports
// Assumes: Only the ports of phylt_regs are seen
// Notes: Bound to phylt_regs after the module
`timescale 1ns/1ps
`default_nettype none
module phylt_regs_properties (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire phylt_pkg::phylt_cfg_req_t cfg_req_in,
  input wire logic [11:0] lane_link_up_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic cfg_rd_valid_out,
  input wire phylt_pkg::phylt_link_ctl_t link_ctl_out,
  input wire phylt_pkg::phylt_port_ctl_t port_ctl_out,
  input wire logic [7:0] even_test_rate_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // History, since control outputs trail a write by two edges
  logic [11:0] lane1_q, lane2_q;
  logic [31:0] wd1_q, wd2_q;
  always_ff @(posedge clk_in) begin
    lane1_q <= lane_link_up_in;
    lane2_q <= lane1_q;
    wd1_q <= cfg_req_in.wdata;
    wd2_q <= wd1_q;
  end
  //////////////////////////////////////////////////////////////////////////
  sequence s_rd(logic [11:0] a);
    cfg_req_in.rd && cfg_req_in.addr[11:2] == a[11:2];
  endsequence
  sequence s_wr(logic [11:0] a, logic [3:0] b);
    cfg_req_in.wr && cfg_req_in.addr[11:2] == a[11:2] &&
      (cfg_req_in.be & b) == b;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  lane_status_a: assert property (
    s_rd(12'h1f4) ##0 !$past(sys_rst_in) |=> cfg_rdata_out ==
      {12'h000, lane2_q[7:4], lane2_q[11:8], 8'h00, lane2_q[3:0]})
    else $error("lane map");
  speed_gate_a: assert property (
    s_rd(12'h208) ##0 !cfg_req_in.upstream |=> cfg_rdata_out == 32'h0)
    else $error("speed gate");
  even_cmd_a: assert property (
    s_rd(12'h220) |=> (cfg_rdata_out & 32'h888f_ff88) == 32'h0)
    else $error("even cmd bits");
  odd_cmd_a: assert property (
    s_rd(12'h224) |=> (cfg_rdata_out & 32'h888f_ff8f) == 32'h0)
    else $error("odd cmd bits");
  port_bits_a: assert property (
    ((port_ctl_out.loopback | port_ctl_out.scrambler_bypass |
      port_ctl_out.compliance_rx) & 16'h03f2) == 16'h0000)
    else $error("test bit port");
  quiet_ports_a: assert property (
    ((port_ctl_out.force_quiet | port_ctl_out.hold_quiet) & 16'habfa) ==
      16'h0000)
    else $error("quiet port");
  hold_map_a: assert property (
    s_wr(12'h230, 4'h3) |=> ##1 port_ctl_out.force_quiet[10] == wd2_q[5] &&
      port_ctl_out.hold_quiet[14] == wd2_q[15])
    else $error("hold map");
  rate_sel_a: assert property (
    s_wr(12'h208, 4'h3) ##0 cfg_req_in.upstream |=> ##1
      link_ctl_out.rate_gen2 == (wd2_q[15:0] == 16'h0001))
    else $error("rate select");
  emph_sel_a: assert property (
    s_wr(12'h208, 4'hc) ##0 cfg_req_in.upstream |=> ##1
      link_ctl_out.emphasis_3p5db == (wd2_q[31:16] == 16'h0001))
    else $error("emphasis select");
  compl_sel_a: assert property (
    s_wr(12'h20c, 4'h3) |=> ##1
      link_ctl_out.compliance_enter == (wd2_q[15:0] == 16'h0001))
    else $error("compliance entry");
endmodule
bind phylt_regs phylt_regs_properties phylt_regs_properties_inst (
  .clk_in, .sys_rst_in, .cfg_req_in, .lane_link_up_in, .cfg_rdata_out,
  .cfg_rd_valid_out, .link_ctl_out, .port_ctl_out, .even_test_rate_out);
`default_nettype wire

// file: test/test_phylt_regs.sv
// Purpose: Self-checking bench for the PHY link test registers
// Assumes: Read answers one edge later; link and port controls trail a write by two, even_test_rate_out by one
// Notes: One idle cycle between accesses keeps strobes clean
`timescale 1ns/1ps
`default_nettype none
module test_phylt_regs;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  phylt_pkg::phylt_cfg_req_t cfg_req_in = '0;
  logic [11:0] lane_link_up_in = 12'h000;
  logic [31:0] cfg_rdata_out;
  logic cfg_rd_valid_out;
  phylt_pkg::phylt_link_ctl_t link_ctl_out;
  phylt_pkg::phylt_port_ctl_t port_ctl_out;
  logic [7:0] even_test_rate_out;
  logic [11:0] offs [6] = '{12'h1f4, 12'h208, 12'h20c, 12'h220, 12'h224,
    12'h230};
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  always #20 clk_in = ~clk_in;
  phylt_regs phylt_regs_inst (.clk_in, .sys_rst_in, .cfg_req_in,
    .lane_link_up_in, .cfg_rdata_out, .cfg_rd_valid_out, .link_ctl_out,
    .port_ctl_out, .even_test_rate_out);
  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("FAIL %0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // Request held across the taking edge, dropped on that same edge
  task automatic access(input logic w, input logic up,
    input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_in);
    cfg_req_in <= '{wr: w, rd: !w, upstream: up, addr: a, be: b, wdata: d};
    @(posedge clk_in);
    cfg_req_in <= '0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] b,
    input logic [31:0] d);
    access(1'b1, 1'b1, a, b, d);
  endtask
  task automatic rd(input logic up, input logic [11:0] a,
    input logic [31:0] exp);
    access(1'b0, up, a, 4'h0, 32'h0);
    check({31'h0, cfg_rd_valid_out}, 32'h1);
    check(cfg_rdata_out, exp);
  endtask
  // Whole run needs well under a hundred cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    foreach (offs[i]) rd(1'b1, offs[i], 32'h0);
    check({29'h0, link_ctl_out}, 32'h0);
    @(posedge clk_in);
    lane_link_up_in <= 12'ha5c;
    wr(12'h1f4, 4'hf, 32'hffff_ffff);
    rd(1'b1, 12'h1f4, 32'h0005_a00c);
    wr(12'h208, 4'hf, 32'h0001_0001);
    rd(1'b1, 12'h208, 32'h0001_0001);
    check({29'h0, link_ctl_out}, 32'h6);
    rd(1'b0, 12'h208, 32'h0);
    access(1'b1, 1'b0, 12'h208, 4'hf, 32'h0);
    rd(1'b1, 12'h208, 32'h0001_0001);
    wr(12'h208, 4'hf, 32'h0002_0000);
    rd(1'b1, 12'h208, 32'h0002_0000);
    check({29'h0, link_ctl_out}, 32'h0);
    wr(12'h20c, 4'hf, 32'hffff_0001);
    rd(1'b1, 12'h20c, 32'h0000_0001);
    check({29'h0, link_ctl_out}, 32'h1);
    wr(12'h20c, 4'hf, 32'h0000_0002);
    rd(1'b1, 12'h20c, 32'h0000_0002);
    check({29'h0, link_ctl_out}, 32'h0);
    wr(12'h220, 4'hf, 32'hffff_ffff);
    rd(1'b1, 12'h220, 32'h7770_0077);
    wr(12'h224, 4'hf, 32'hffff_ffff);
    rd(1'b1, 12'h224, 32'h7770_0070);
    check({port_ctl_out.loopback, port_ctl_out.compliance_rx},
      32'hfc0d_fc0d);
    check({16'h0, port_ctl_out.scrambler_bypass}, 32'h0000_fc0d);
    wr(12'h220, 4'h8, 32'h0000_0000);
    rd(1'b1, 12'h220, 32'h0070_0077);
    wr(12'h230, 4'hf, 32'hffff_ffff);
    rd(1'b1, 12'h230, 32'h00ff_e3e3);
    check({port_ctl_out.force_quiet, port_ctl_out.hold_quiet},
      32'h5405_5405);
    check({24'h0, even_test_rate_out}, 32'h0000_00ff);
    wr(12'h230, 4'hf, 32'h0000_8020);
    rd(1'b1, 12'h230, 32'h0000_8020);
    check({port_ctl_out.force_quiet, port_ctl_out.hold_quiet},
      32'h0400_4000);
    rd(1'b1, 12'h210, 32'h0);
    results();
  end
endmodule
`default_nettype wire
